// ==== design/gg_avg_filter.sv ====
// exponential running-average filter, window of 2^shift samples
`timescale 1ns/10ps
module gg_avg_filter #(
	parameter int unsigned WIDTH = 17,
	parameter int unsigned FRAC  = 13
)(
	input  wire logic                    clk_sys_in,
	input  wire logic                    reset_n_in,
	input  wire logic                    sample_valid_in,
	input  wire logic signed [WIDTH-1:0] sample_in,
	input  wire logic        [3:0]       shift_in,
	output logic signed      [WIDTH-1:0] avg_out
);

	localparam int unsigned AW = WIDTH + FRAC;

	generate
		if (FRAC < 13 || WIDTH < 2)
		begin : g_bad
			$error("gg_avg_filter needs FRAC of at least 13 and WIDTH of at least 2");
		end
	endgenerate

	logic signed [AW-1:0] acc;
	logic                 primed;
	logic signed [AW:0]   target;
	logic signed [AW:0]   step;
	logic signed [AW-1:0] next_acc;

	always_comb
	begin
		target   = $signed({sample_in[WIDTH-1], sample_in, {FRAC{1'b0}}});
		step     = (target - $signed({acc[AW-1], acc})) >>> shift_in;
		next_acc = acc + step[AW-1:0];
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			acc     <= '0;
			primed  <= 1'b0;
			avg_out <= '0;
		end
		else if (sample_valid_in)
		begin
			primed <= 1'b1;
			if (!primed)
			begin
				// first sample seeds the filter
				acc     <= target[AW-1:0];
				avg_out <= sample_in;
			end
			else
			begin
				acc     <= next_acc;
				avg_out <= next_acc[AW-1:FRAC];
			end
		end
	end

endmodule

// ==== design/gg_gauge_regs.sv ====
// gauge status flags and measurement result registers behind a two-wire serial slave
// How it works
// - POR flag set on any power-on reset, held until software clears it
// - battery-absent bit is 0 with battery present, 1 once removed
// - voltage sample below/above alert limits sets under/over-voltage flags
// - temperature below/above alert limits sets low/high temperature flags
// - charge below/above alert limits sets low/high charge flags
// - sticky setting decides between self-clearing and software-cleared threshold flags
// - insertion seen on thermistor input sets insertion flag until cleared
// - removal seen sets removal flag until software clears it
// - unassigned status bits are don't-care; here they read zero
// - read-only 16-bit silicon revision word
// - new voltage sample every task period in active mode, 0.625mV steps
// - voltage saturates at max code; low three bits are don't-care
// - voltage sample and average hold their values through shutdown
// - running voltage average over a selectable window of 11.25s to 24min
// - first voltage sample after power-up seeds the average
// - relaxation switches averaging window; current flow restores normal window
// - each sample updates stored maximum and minimum if exceeded
// - peaks are 8-bit 20mV fields, power up 00h/ffh, 00ffh write reinitialises
// - signed current sample stored every task period in active mode
// - current beyond range saturates at the minimum or maximum code
// - current sample and average read 0000h until first conversion, held in shutdown
// - current equals raw times gain over 16384 plus twice offset
// - voltage sticky 1 clears by software only, 0 clears automatically
`timescale 1ns/10ps
`include "gg_consts.svh"
module gg_gauge_regs #(
	parameter int unsigned TASK_CYCLES      = `GG_TASK_PERIOD_US * `GG_CLK_FREQ_MHZ,
	parameter logic [15:0] SILICON_REVISION = 16'h0001, // arbitrary value
	parameter logic [6:0]  DEVICE_ADDR      = `GG_I2C_ADDR,
	parameter int unsigned VRAW_W           = 14,
	parameter int unsigned IRAW_W           = 17
)(
	input  wire logic                     clk_sys_in,
	input  wire logic                     reset_n_in,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out_out,
	output logic                          sda_oe_out,
	input  wire logic                     thermistor_input_in,
	input  wire logic                     active_mode_in,
	input  wire logic                     soft_por_in,
	input  wire logic [VRAW_W-1:0]        cell_voltage_sample_raw_in,
	input  wire logic signed [IRAW_W-1:0] current_raw_in,
	input  wire logic [15:0]              current_gain_word_in,
	input  wire logic [15:0]              current_offset_word_in,
	input  wire logic [15:0]              voltage_alert_threshold_in,
	input  wire logic                     temp_update_in,
	input  wire logic [15:0]              temperature_in,
	input  wire logic [15:0]              temperature_alert_threshold_in,
	input  wire logic                     soc_update_in,
	input  wire logic [15:0]              soc_in,
	input  wire logic [15:0]              charge_alert_threshold_in,
	input  wire logic                     voltage_sticky_setting_in,
	input  wire logic                     temperature_sticky_setting_in,
	input  wire logic                     charge_sticky_setting_in,
	input  wire logic [2:0]               averaging_filter_settings_in,
	input  wire logic [3:0]               relaxation_average_period_in,
	input  wire logic                     relax_event_in,
	input  wire logic                     current_flow_in
);

	localparam int unsigned CW = IRAW_W + 17;
	localparam int FLAG_POS [9] = '{`GG_BIT_VMN, `GG_BIT_TMN, `GG_BIT_SMN, `GG_BIT_BI,
		`GG_BIT_VMX, `GG_BIT_TMX, `GG_BIT_SMX, `GG_BIT_BR, `GG_BIT_POR};

	generate
		if (TASK_CYCLES < 2 || VRAW_W < 14 || VRAW_W > 24 || IRAW_W < 16 || IRAW_W > 24)
		begin : g_bad
			$error("gg_gauge_regs parameter out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// pins and task period

	logic [2:0]  pins_q;
	logic        scl_q;
	logic        sda_q;
	logic        removed_q;
	logic        scl_d;
	logic        sda_d;
	logic        removed_d;
	logic [31:0] tick_cnt;
	logic        task_tick;
	logic        sample_upd;

	gg_pin_sync #(
		.WIDTH     (3),
		.RESET_VAL (3'b110)
	) u_pin_sync (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.pin_in     ({scl_in, sda_in, thermistor_input_in}),
		.level_out  (pins_q)
	);

	assign scl_q     = pins_q[2];
	assign sda_q     = pins_q[1];
	assign removed_q = pins_q[0];

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			scl_d     <= 1'b1;
			sda_d     <= 1'b1;
			removed_d <= 1'b0;
		end
		else
		begin
			scl_d     <= scl_q;
			sda_d     <= sda_q;
			removed_d <= removed_q;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			tick_cnt  <= '0;
			task_tick <= 1'b0;
		end
		else if (tick_cnt == 32'(TASK_CYCLES - 1))
		begin
			tick_cnt  <= '0;
			task_tick <= 1'b1;
		end
		else
		begin
			tick_cnt  <= tick_cnt + 32'h1;
			task_tick <= 1'b0;
		end
	end

	// in shutdown the results simply stop updating and keep their values
	assign sample_upd = task_tick & active_mode_in;

	////////////////////////////////////////////////////////////////////////////
	// voltage and current results

	logic        [15:0]       cell_voltage_sample;
	logic        [15:0]       next_cell_voltage_sample;
	logic        [15:0]       current;
	logic        [15:0]       next_current;
	logic signed [CW-2:0]     cur_prod;
	logic signed [CW-2:0]     cur_scaled;
	logic signed [CW-1:0]     cur_sum;
	logic signed [16:0]       vavg;
	logic signed [16:0]       iavg;
	logic                     relax_mode;
	logic        [4:0]        relax_shift;
	logic        [3:0]        avg_shift;

	always_comb
	begin
		if (cell_voltage_sample_raw_in > VRAW_W'(`GG_CELL_VOLTAGE_SAMPLE_MAX_CODE))
			next_cell_voltage_sample = {`GG_CELL_VOLTAGE_SAMPLE_MAX_CODE, `GG_CELL_VOLTAGE_SAMPLE_DC_BITS};
		else
			next_cell_voltage_sample = {cell_voltage_sample_raw_in[12:0], `GG_CELL_VOLTAGE_SAMPLE_DC_BITS};
	end

	always_comb
	begin
		cur_prod   = current_raw_in * $signed(current_gain_word_in);
		cur_scaled = cur_prod >>> `GG_CURRENT_GAIN_WORD_SHIFT;
		cur_sum    = CW'(cur_scaled) + CW'($signed({current_offset_word_in, 1'b0}));
		if (cur_sum > CW'($signed(`GG_CUR_MAX_CODE)))
			next_current = `GG_CUR_MAX_CODE;
		else if (cur_sum < CW'($signed(`GG_CUR_MIN_CODE)))
			next_current = `GG_CUR_MIN_CODE;
		else
			next_current = cur_sum[15:0];
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			cell_voltage_sample   <= `GG_CELL_VOLTAGE_SAMPLE_RESET;
			current <= `GG_CURRENT_RESET;
		end
		else if (sample_upd)
		begin
			cell_voltage_sample   <= next_cell_voltage_sample;
			current <= next_current;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
			relax_mode <= 1'b0;
		else if (relax_event_in)
			relax_mode <= 1'b1;
		else if (current_flow_in)
			relax_mode <= 1'b0;
	end

	// window sizes are powers of two; longest window caps the relaxation setting
	always_comb
	begin
		relax_shift = 5'(`GG_AVG_BASE_SHIFT) + 5'(relaxation_average_period_in);
		if (!relax_mode)
			avg_shift = `GG_AVG_BASE_SHIFT + 4'(averaging_filter_settings_in);
		else if (relax_shift > 5'(`GG_AVG_MAX_SHIFT))
			avg_shift = `GG_AVG_MAX_SHIFT;
		else
			avg_shift = relax_shift[3:0];
	end

	gg_avg_filter #(
		.WIDTH (17),
		.FRAC  (13)
	) u_vavg (
		.clk_sys_in      (clk_sys_in),
		.reset_n_in      (reset_n_in),
		.sample_valid_in (sample_upd),
		.sample_in       ($signed({1'b0, next_cell_voltage_sample})),
		.shift_in        (avg_shift),
		.avg_out         (vavg)
	);

	gg_avg_filter #(
		.WIDTH (17),
		.FRAC  (13)
	) u_iavg (
		.clk_sys_in      (clk_sys_in),
		.reset_n_in      (reset_n_in),
		.sample_valid_in (sample_upd),
		.sample_in       ($signed({next_current[15], next_current})),
		.shift_in        (avg_shift),
		.avg_out         (iavg)
	);

	////////////////////////////////////////////////////////////////////////////
	// peaks and status flags

	logic [7:0]  peak_max;
	logic [7:0]  peak_min;
	logic [7:0]  cell_voltage_sample_coarse;
	logic        wr_stb;
	logic [7:0]  wr_ptr;
	logic [15:0] wr_word;
	logic        wr_status;
	logic [8:0]  flag;
	logic [8:0]  cond;
	logic [8:0]  upd;
	logic [8:0]  sticky;
	logic [15:0] status_word;

	// 20mV steps are the top byte of the 0.625mV sample
	assign cell_voltage_sample_coarse = next_cell_voltage_sample[15:8];
	assign wr_status    = wr_stb && (wr_ptr == `GG_OFS_STATUS);

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			peak_max <= `GG_PEAK_MAX_INIT;
			peak_min <= `GG_PEAK_MIN_INIT;
		end
		else if (wr_stb && wr_ptr == `GG_OFS_PEAKS)
		begin
			peak_max <= wr_word[15:8];
			peak_min <= wr_word[7:0];
		end
		else if (sample_upd)
		begin
			if (cell_voltage_sample_coarse > peak_max)
				peak_max <= cell_voltage_sample_coarse;
			if (cell_voltage_sample_coarse < peak_min)
				peak_min <= cell_voltage_sample_coarse;
		end
	end

	always_comb
	begin
		cond[0] = cell_voltage_sample_coarse < voltage_alert_threshold_in[7:0];
		cond[4] = cell_voltage_sample_coarse > voltage_alert_threshold_in[15:8];
		cond[1] = $signed(temperature_in[15:8]) < $signed(temperature_alert_threshold_in[7:0]);
		cond[5] = $signed(temperature_in[15:8]) > $signed(temperature_alert_threshold_in[15:8]);
		cond[2] = soc_in[15:8] < charge_alert_threshold_in[7:0];
		cond[6] = soc_in[15:8] > charge_alert_threshold_in[15:8];
		cond[3] = 1'b1;
		cond[7] = 1'b1;
		cond[8] = 1'b1;
		upd[0]  = sample_upd;
		upd[4]  = sample_upd;
		upd[1]  = temp_update_in;
		upd[5]  = temp_update_in;
		upd[2]  = soc_update_in;
		upd[6]  = soc_update_in;
		upd[3]  = removed_d & ~removed_q;
		upd[7]  = ~removed_d & removed_q;
		upd[8]  = soft_por_in;
		sticky  = {2'b11, charge_sticky_setting_in, temperature_sticky_setting_in,
			voltage_sticky_setting_in, 1'b1, charge_sticky_setting_in,
			temperature_sticky_setting_in, voltage_sticky_setting_in};
	end

	genvar f;
	generate
		for (f = 0; f < 9; f++)
		begin : g_flag
			// a set in the same cycle as a clear wins, so no event is lost
			always_ff @(posedge clk_sys_in)
			begin
				if (!reset_n_in)
					flag[f] <= 1'(f == 8);
				else if (upd[f] && cond[f])
					flag[f] <= 1'b1;
				else if (upd[f] && !sticky[f])
					flag[f] <= 1'b0;
				else if (wr_status && !wr_word[FLAG_POS[f]])
					flag[f] <= 1'b0;
			end
		end
	endgenerate

	always_comb
	begin
		status_word = '0;
		for (int k = 0; k < 9; k++)
			status_word[FLAG_POS[k]] = flag[k];
		status_word[`GG_BIT_BST] = removed_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// two-wire serial slave: pointer byte, then words low byte first

	gg_pkg::gg_i2c_state_e state;
	gg_pkg::gg_i2c_state_e ack_next;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg;
	logic [7:0]  tx;
	logic [7:0]  ptr;
	logic [7:0]  wr_lo;
	logic [15:0] rd_hold;
	logic [15:0] rd_mux;
	logic        hi_byte;
	logic        nack;
	logic        i2c_start;
	logic        i2c_stop;
	logic        scl_rise;
	logic        scl_fall;
	logic        load_now;

	assign scl_rise  = scl_q & ~scl_d;
	assign scl_fall  = ~scl_q & scl_d;
	assign i2c_start = scl_q & scl_d & sda_d & ~sda_q;
	assign i2c_stop  = scl_q & scl_d & ~sda_d & sda_q;
	assign load_now  = scl_fall && ((state == gg_pkg::GG_ST_ACK && ack_next == gg_pkg::GG_ST_RDATA)
		|| (state == gg_pkg::GG_ST_RACK && !nack));

	always_comb
	begin
		case (ptr)
			`GG_OFS_STATUS:      rd_mux = status_word;
			`GG_OFS_CELL_VOLTAGE_SAMPLE:       rd_mux = cell_voltage_sample;
			`GG_OFS_CURRENT:     rd_mux = current;
			`GG_OFS_AVG_CURRENT: rd_mux = iavg[15:0];
			`GG_OFS_AVG_CELL_VOLTAGE_SAMPLE:   rd_mux = {vavg[15:3], `GG_CELL_VOLTAGE_SAMPLE_DC_BITS};
			`GG_OFS_PEAKS:       rd_mux = {peak_max, peak_min};
			`GG_OFS_REVISION:    rd_mux = SILICON_REVISION;
			default:             rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
			sda_out_out <= 1'b0;
		else
			sda_out_out <= 1'b0;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			state      <= gg_pkg::GG_ST_IDLE;
			ack_next   <= gg_pkg::GG_ST_IDLE;
			bit_cnt    <= '0;
			shreg      <= '0;
			tx         <= '0;
			ptr        <= '0;
			wr_lo      <= '0;
			rd_hold    <= '0;
			hi_byte    <= 1'b0;
			nack       <= 1'b0;
			wr_stb     <= 1'b0;
			wr_ptr     <= '0;
			wr_word    <= '0;
			sda_oe_out <= 1'b0;
		end
		else
		begin
			wr_stb <= 1'b0;
			if (i2c_start)
			begin
				state      <= gg_pkg::GG_ST_ADDR;
				bit_cnt    <= '0;
				sda_oe_out <= 1'b0;
			end
			else if (i2c_stop)
			begin
				state      <= gg_pkg::GG_ST_IDLE;
				sda_oe_out <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (state == gg_pkg::GG_ST_RACK)
					nack <= sda_q;
				else if (state != gg_pkg::GG_ST_IDLE && state != gg_pkg::GG_ST_ACK)
				begin
					shreg   <= {shreg[6:0], sda_q};
					bit_cnt <= bit_cnt + 4'h1;
				end
			end
			else if (scl_fall)
			begin
				case (state)
					gg_pkg::GG_ST_ADDR:
					begin
						if (bit_cnt == 4'h8 && shreg[7:1] == DEVICE_ADDR)
						begin
							sda_oe_out <= 1'b1;
							hi_byte    <= 1'b0;
							state      <= gg_pkg::GG_ST_ACK;
							ack_next   <= shreg[0] ? gg_pkg::GG_ST_RDATA : gg_pkg::GG_ST_PTR;
						end
						else if (bit_cnt == 4'h8)
							state <= gg_pkg::GG_ST_IDLE;
					end
					gg_pkg::GG_ST_PTR:
					begin
						if (bit_cnt == 4'h8)
						begin
							ptr        <= shreg;
							hi_byte    <= 1'b0;
							sda_oe_out <= 1'b1;
							state      <= gg_pkg::GG_ST_ACK;
							ack_next   <= gg_pkg::GG_ST_WDATA;
						end
					end
					gg_pkg::GG_ST_WDATA:
					begin
						if (bit_cnt == 4'h8)
						begin
							hi_byte    <= ~hi_byte;
							sda_oe_out <= 1'b1;
							state      <= gg_pkg::GG_ST_ACK;
							ack_next   <= gg_pkg::GG_ST_WDATA;
							if (!hi_byte)
								wr_lo <= shreg;
							else
							begin
								// only a whole word commits; a lone low byte is dropped
								wr_stb  <= 1'b1;
								wr_ptr  <= ptr;
								wr_word <= {shreg, wr_lo};
								ptr     <= ptr + 8'h1;
							end
						end
					end
					gg_pkg::GG_ST_ACK:
					begin
						bit_cnt    <= '0;
						state      <= ack_next;
						sda_oe_out <= 1'b0;
					end
					gg_pkg::GG_ST_RDATA:
					begin
						if (bit_cnt == 4'h8)
						begin
							sda_oe_out <= 1'b0;
							state      <= gg_pkg::GG_ST_RACK;
						end
						else
						begin
							sda_oe_out <= ~tx[7];
							tx         <= {tx[6:0], 1'b0};
						end
					end
					gg_pkg::GG_ST_RACK:
					begin
						bit_cnt <= '0;
						state   <= nack ? gg_pkg::GG_ST_IDLE : gg_pkg::GG_ST_RDATA;
					end
					default:
						state <= gg_pkg::GG_ST_IDLE;
				endcase
				if (load_now && !hi_byte)
				begin
					// the word is captured whole so its two bytes always match
					rd_hold    <= rd_mux;
					sda_oe_out <= ~rd_mux[7];
					tx         <= {rd_mux[6:0], 1'b0};
					hi_byte    <= 1'b1;
				end
				else if (load_now)
				begin
					sda_oe_out <= ~rd_hold[15];
					tx         <= {rd_hold[14:8], 1'b0};
					hi_byte    <= 1'b0;
					ptr        <= ptr + 8'h1;
				end
			end
		end
	end

endmodule

// ==== design/gg_pin_sync.sv ====
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/10ps
module gg_pin_sync #(
	parameter int unsigned        WIDTH     = 1,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
)(
	input  wire logic             clk_sys_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	generate
		if (WIDTH < 1)
		begin : g_bad
			$error("gg_pin_sync needs at least one bit");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic stage1;
			logic stage2;
			logic stage3;

			always_ff @(posedge clk_sys_in)
			begin
				if (!reset_n_in)
				begin
					stage1 <= RESET_VAL[i];
					stage2 <= RESET_VAL[i];
					stage3 <= RESET_VAL[i];
				end
				else
				begin
					stage1 <= pin_in[i];
					stage2 <= stage1;
					stage3 <= stage2;
				end
			end

			// a change counts only once the second and third stages agree
			always_ff @(posedge clk_sys_in)
			begin
				if (!reset_n_in)
					level_out[i] <= RESET_VAL[i];
				else if (stage2 == stage3)
					level_out[i] <= stage3;
			end
		end
	endgenerate

endmodule

// ==== dv/gg_gauge_regs_assertions.sv ====
// pin-level assertions for the gauge register block
`timescale 1ns/10ps
module gg_regs_chk (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic scl_in,
	input  wire logic sda_out_out,
	input  wire logic sda_oe_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	property p_rst_quiet;
		$rose(reset_n_in) |-> !sda_oe_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("data line driven out of reset");
	property p_open_drain;
		sda_oe_out |-> !sda_out_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data line driven high");
	// filtered clock lags the pin, so a legal change sees the pin low for some cycles
	property p_drive_on_low;
		$changed(sda_oe_out) |-> !scl_in && $past(scl_in, 3) == 1'h0;
	endproperty
	a_drive_on_low: assert property (p_drive_on_low) else $error("data changed while clock high");
	// filter plus edge detect puts every data move six samples after the pin fall
	property p_fall_latency;
		$changed(sda_oe_out) |-> $past(scl_in, 6) && !$past(scl_in, 5);
	endproperty
	a_fall_latency: assert property (p_fall_latency) else $error("data moved off the clock fall");
	property p_rst_hold;
		disable iff (1'b0) !reset_n_in |=> !sda_oe_out && !sda_out_out;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("data line active in reset");
	property p_rst_settle;
		$rose(reset_n_in) |-> !sda_oe_out [*6];
	endproperty
	a_rst_settle: assert property (p_rst_settle) else $error("data line driven while pins settle");
endmodule
bind gg_gauge_regs gg_regs_chk u_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
	.sda_out_out(sda_out_out), .sda_oe_out(sda_oe_out));

// ==== dv/gg_host_model.sv ====
// two-wire bus host model: open-drain data, word reads and writes
`timescale 1ns/10ps
`include "gg_consts.svh"
module gg_host_model (
	input  wire logic   clk_sys_in,
	input  wire logic   sda_oe_in,
	output logic        scl_out,
	output logic        sda_wire_out,
	output logic [15:0] rd_word_out,
	output logic        rd_done_out
);
	logic pull;
	// pull-up: released line reads high
	assign sda_wire_out = !(pull || sda_oe_in);
	initial
	begin
		scl_out = 1'h1;
		pull = 1'h0;
		rd_done_out = 1'h0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	// data moves well after the fall so filtered pins never see a false start
	task automatic bit_io(input logic b, output logic s);
		pull = !b;
		tk(12);
		scl_out = 1'h1;
		tk(12);
		s = sda_wire_out;
		scl_out = 1'h0;
		tk(6);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack, s);
	endtask
	task automatic start_c;
		pull = 1'h0;
		tk(12);
		scl_out = 1'h1;
		tk(12);
		pull = 1'h1;
		tk(12);
		scl_out = 1'h0;
		tk(6);
	endtask
	task automatic stop_c;
		pull = 1'h1;
		tk(12);
		scl_out = 1'h1;
		tk(12);
		pull = 1'h0;
		tk(12);
	endtask
	task automatic wr_word(input logic [7:0] ofs, input logic [15:0] d);
		logic [7:0] q;
		start_c;
		byte_io({`GG_I2C_ADDR, 1'h0}, 1'h1, q);
		byte_io(ofs, 1'h1, q);
		byte_io(d[7:0], 1'h1, q);
		byte_io(d[15:8], 1'h1, q);
		stop_c;
	endtask
	task automatic rd_word(input logic [7:0] ofs);
		logic [7:0] q;
		start_c;
		byte_io({`GG_I2C_ADDR, 1'h0}, 1'h1, q);
		byte_io(ofs, 1'h1, q);
		start_c;
		byte_io({`GG_I2C_ADDR, 1'h1}, 1'h1, q);
		byte_io(8'hff, 1'h0, rd_word_out[7:0]);
		byte_io(8'hff, 1'h1, rd_word_out[15:8]);
		stop_c;
		rd_done_out = 1'h1;
		tk(1);
		rd_done_out = 1'h0;
	endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the gauge register block
`timescale 1ns/10ps
`include "gg_consts.svh"
module tb_top;
	localparam int TC = 200;
	localparam logic [7:0] ST = `GG_OFS_STATUS;
	logic               clk_sys_in = 1'h0;
	logic               reset_n_in, scl, sda, sda_oe, therm, active, soft_por, rd_done, vs, tupd, supd;
	logic [13:0]        vraw;
	logic signed [16:0] iraw;
	logic [15:0]        gain, offs, vthr, tthr, sthr, temp, soc, rd_word, lfsr;
	logic [12:0]        vb;
	logic [15:0]        exp_q[$];
	int                 err_total, num_checks;
	always #4 clk_sys_in = !clk_sys_in;
	gg_gauge_regs #(.TASK_CYCLES(TC)) DUT (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl),
		.sda_in(sda), .sda_out_out(), .sda_oe_out(sda_oe), .thermistor_input_in(therm),
		.active_mode_in(active), .soft_por_in(soft_por), .cell_voltage_sample_raw_in(vraw), .current_raw_in(iraw),
		.current_gain_word_in(gain), .current_offset_word_in(offs), .voltage_alert_threshold_in(vthr),
		.temp_update_in(tupd), .temperature_in(temp), .temperature_alert_threshold_in(tthr),
		.soc_update_in(supd), .soc_in(soc), .charge_alert_threshold_in(sthr),
		.voltage_sticky_setting_in(vs), .temperature_sticky_setting_in(1'h1), .charge_sticky_setting_in(1'h1),
		.averaging_filter_settings_in(3'h0), .relaxation_average_period_in(4'h0), .relax_event_in(tupd),
		.current_flow_in(1'h0));
	gg_host_model host (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_wire_out(sda),
		.rd_word_out(rd_word), .rd_done_out(rd_done));
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic rd(input logic [7:0] ofs, input logic [15:0] want);
		exp_q.push_back(want);
		host.rd_word(ofs);
	endtask
	task automatic cur(input logic [16:0] r, input logic [15:0] g, input logic [15:0] o, input logic [15:0] e);
		iraw = r;
		gain = g;
		offs = o;
		tk(TC + 5);
		rd(`GG_OFS_CURRENT, e);
	endtask
	task automatic close_out;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge rd_done)
		chk(rd_word, exp_q.pop_front());
	initial
	begin
		repeat (90000) @(posedge clk_sys_in);
		err_total++;
		close_out;
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		{reset_n_in, therm, active, soft_por, vs, tupd, supd} = 7'h00;
		{vraw, iraw, offs, temp, soc} = 79'h0;
		gain = 16'h4000;
		vthr = 16'hff00;
		tthr = 16'h7ff0;
		sthr = 16'hff00;
		lfsr = 16'h9187; // seed 37255
		tk(4);
		reset_n_in = 1'h1;
		tk(8);
		rd(ST, 16'h0002);
		rd(`GG_OFS_REVISION, 16'h0001);
		rd(`GG_OFS_PEAKS, 16'h00ff);
		rd(`GG_OFS_CURRENT, 16'h0000);
		rd(`GG_OFS_AVG_CURRENT, 16'h0000);
		host.wr_word(ST, 16'h0000);
		rd(ST, 16'h0000);
		soft_por = 1'h1;
		tk(1);
		soft_por = 1'h0;
		rd(ST, 16'h0002);
		host.wr_word(ST, 16'h0000);
		therm = 1'h1;
		tk(10);
		rd(ST, 16'h8008);
		host.wr_word(ST, 16'h0000);
		rd(ST, 16'h0008);
		therm = 1'h0;
		tk(10);
		rd(ST, 16'h0800);
		host.wr_word(ST, 16'h0000);
		lfsr = nxt(lfsr);
		vb = lfsr[12:0];
		vraw = {1'h0, vb};
		active = 1'h1;
		tk(TC + 5);
		rd(`GG_OFS_CELL_VOLTAGE_SAMPLE, {vb, 3'h0});
		rd(`GG_OFS_AVG_CELL_VOLTAGE_SAMPLE, {vb, 3'h0});
		rd(`GG_OFS_PEAKS, {vb[12:5], vb[12:5]});
		lfsr = nxt(lfsr);
		cur({lfsr[15], lfsr}, 16'h4000, 16'h0000, lfsr);
		cur(17'h0ffff, 16'h4000, 16'h0000, 16'h7fff);
		cur(17'h10000, 16'h4000, 16'h0000, 16'h8000);
		cur(17'h00100, 16'h2000, 16'h0020, 16'h00c0);
		active = 1'h0;
		host.wr_word(`GG_OFS_PEAKS, 16'h00ff);
		vraw = 14'h3fff;
		tk(TC + 5);
		rd(`GG_OFS_PEAKS, 16'h00ff);
		rd(`GG_OFS_CELL_VOLTAGE_SAMPLE, {vb, 3'h0});
		rd(`GG_OFS_AVG_CELL_VOLTAGE_SAMPLE, {vb, 3'h0});
		rd(`GG_OFS_CURRENT, 16'h00c0);
		active = 1'h1;
		tk(TC + 5);
		rd(`GG_OFS_CELL_VOLTAGE_SAMPLE, 16'hfff8);
		rd(`GG_OFS_PEAKS, 16'hffff);
		vraw = 14'h0400;
		vthr = 16'h1005;
		tk(TC + 5);
		rd(ST, 16'h1000);
		vthr = 16'hff30;
		tk(TC + 5);
		rd(ST, 16'h0100);
		vs = 1'h1;
		vthr = 16'h1005;
		sthr = 16'h5000;
		temp = 16'h8000;
		soc = 16'h6400;
		{tupd, supd} = 2'h3;
		tk(1);
		{tupd, supd} = 2'h0;
		tk(TC + 5);
		vthr = 16'hff00;
		tk(TC + 5);
		rd(ST, 16'h5300);
		host.wr_word(ST, 16'h0000);
		rd(ST, 16'h0000);
		close_out;
	end
endmodule

// ==== pkg/gg_consts.svh ====
// offsets, field positions, reset values and timing figures of the gauge register block
`ifndef GG_CONSTS_SVH
`define GG_CONSTS_SVH

// register offsets, one 16-bit word each
`define GG_OFS_STATUS      8'h00
`define GG_OFS_CELL_VOLTAGE_SAMPLE       8'h09
`define GG_OFS_CURRENT     8'h0a
`define GG_OFS_AVG_CURRENT 8'h0b
`define GG_OFS_AVG_CELL_VOLTAGE_SAMPLE   8'h19
`define GG_OFS_PEAKS       8'h1b
`define GG_OFS_REVISION    8'h21

// status word bit positions
`define GG_BIT_POR 1
`define GG_BIT_BST 3
`define GG_BIT_VMN 8
`define GG_BIT_TMN 9
`define GG_BIT_SMN 10
`define GG_BIT_BI  11
`define GG_BIT_VMX 12
`define GG_BIT_TMX 13
`define GG_BIT_SMX 14
`define GG_BIT_BR  15

// reset values and codes
`define GG_PEAK_MAX_INIT  8'h00
`define GG_PEAK_MIN_INIT  8'hff
`define GG_CURRENT_RESET  16'h0000
`define GG_CELL_VOLTAGE_SAMPLE_RESET    16'h0000
`define GG_CELL_VOLTAGE_SAMPLE_MAX_CODE 13'h1fff
`define GG_CELL_VOLTAGE_SAMPLE_DC_BITS  3'h0
`define GG_CUR_MAX_CODE   16'h7fff
`define GG_CUR_MIN_CODE   16'h8000
`define GG_CURRENT_GAIN_WORD_SHIFT    14
`define GG_AVG_BASE_SHIFT 4'h6
`define GG_AVG_MAX_SHIFT  4'hd
`define GG_I2C_ADDR       7'h2a

// timing
`define GG_CLK_FREQ_MHZ   125
`define GG_TASK_PERIOD_US 175800

`endif

// ==== pkg/gg_pkg.sv ====
// types shared by the gauge register block
package gg_pkg;

	typedef enum logic [2:0]
	{
		GG_ST_IDLE,
		GG_ST_ADDR,
		GG_ST_PTR,
		GG_ST_WDATA,
		GG_ST_ACK,
		GG_ST_RDATA,
		GG_ST_RACK
	} gg_i2c_state_e;

endpackage
